// ### design/fsr_pkg.sv
// constants and types shared by the flash status register block
package fsr_pkg;

  // ------------------------------------------------------------------
  // command opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] FSR_OP_READ_STATUS = 8'h05;
  localparam logic [7:0] FSR_OP_WRITE_SR1   = 8'h01;

  // ------------------------------------------------------------------
  // status byte one field positions
  // ------------------------------------------------------------------
  localparam int FSR_B1_LOCK  = 7;
  localparam int FSR_B1_RSV   = 6;
  localparam int FSR_B1_ERR   = 5;
  localparam int FSR_B1_WPP   = 4;
  localparam int FSR_B1_SWP_H = 3;
  localparam int FSR_B1_SWP_L = 2;
  localparam int FSR_B1_WEL   = 1;
  localparam int FSR_BX_BUSY  = 0;

  // ------------------------------------------------------------------
  // status byte two field positions
  // ------------------------------------------------------------------
  localparam int FSR_B2_RSV_H = 7;
  localparam int FSR_B2_RSV_L = 5;
  localparam int FSR_B2_RESET_COMMAND_ENABLE  = 4;
  localparam int FSR_B2_SLE   = 3;
  localparam int FSR_B2_PS    = 2;
  localparam int FSR_B2_ES    = 1;

  // ------------------------------------------------------------------
  // reset values and encodings
  // ------------------------------------------------------------------
  localparam logic       FSR_LOCK_RST = 1'b0;
  localparam logic       FSR_ERR_RST  = 1'b0;
  localparam logic       FSR_WEL_RST  = 1'b0;
  localparam logic       FSR_RESET_COMMAND_ENABLE_RST = 1'b0;
  localparam logic       FSR_SLE_RST  = 1'b0;
  localparam logic [1:0] FSR_SWP_NONE = 2'h0;
  localparam logic [1:0] FSR_SWP_SOME = 2'h1;
  localparam logic [1:0] FSR_SWP_ALL  = 2'h3;
  localparam logic [2:0] FSR_RSV2     = 3'h0;
  localparam logic [2:0] FSR_LAST_BIT = 3'h7;
  localparam logic [2:0] FSR_BIT0     = 3'h0;
  // sync input order: sclk, cs_n, si, wp_n; idle levels, sclk low
  localparam logic [3:0] FSR_PIN_RST  = 4'h5;

  // ------------------------------------------------------------------
  // command decode state
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    FSR_M_OPCODE,
    FSR_M_READ,
    FSR_M_WSR1,
    FSR_M_WSR2,
    FSR_M_WREN,
    FSR_M_WRDI,
    FSR_M_SKIP
  } fsr_mode_t;

endpackage

// ### design/fsr_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none

module fsr_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= RST;
      sync_reg <= RST;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule

`default_nettype wire

// ### design/fsr_status.sv
// serial flash status register bank with its read and write commands
`timescale 1ns/100ps
`default_nettype none

// How it works
// RULE1 - opcode 05h under chip select reads status
// RULE2 - output byte one, byte two, repeating
// RULE3 - live status per byte; busy in bit 0
// RULE4 - status read accepted even while busy
// RULE5 - host reads four bytes at fast clocks
// RULE6 - chip select release ends read, output floats
// RULE7 - byte one bit 7 is protection lock
// RULE8 - reserved bits read zero
// RULE9 - byte one bit 5 is error flag
// RULE10 - error flag refreshed after each operation
// RULE11 - aborted operations never set error flag
// RULE12 - byte one bit 4 mirrors write protect
// RULE13 - bits 3:2 give protection summary
// RULE14 - byte one bit 1 is write enable latch
// RULE15 - busy bit reads 1 during operations
// RULE16 - byte two bit 4 reset command enable
// RULE17 - byte two bit 3 lockdown commands enable
// RULE18 - byte two bits 2,1 suspend flags
// RULE19 - status writes change only writable bits
// RULE20 - lock set blocks protection changes
// RULE21 - lock clears at power-up, not soft reset
// RULE22 - write protect allows lock only 0 to 1
// RULE23 - byte one written by opcode 01h plus data
// RULE24 - refused lock clear still clears write enable
// RULE25 - msb first, changed after falling clock
module fsr_status
  import fsr_pkg::*;
#(
  parameter logic [7:0] OP_WRITE_SR2 = 8'h31,
  parameter logic [7:0] OP_WREN      = 8'h06,
  parameter logic [7:0] OP_WRDI      = 8'h04
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_spi_sclk,
  input  wire logic       i_spi_cs_n,
  input  wire logic       i_spi_si,
  input  wire logic       i_wp_n,
  input  wire logic       i_busy,
  input  wire logic       i_op_done,
  input  wire logic       i_op_fail,
  input  wire logic       i_op_abort,
  input  wire logic [1:0] i_software_protect_summary,
  input  wire logic       i_program_suspended_flag,
  input  wire logic       i_erase_suspended_flag,
  input  wire logic       i_lockdown_frozen,
  input  wire logic       i_wel_clear,
  output logic            o_spi_so,
  output logic            o_spi_so_oe,
  output logic            o_protection_lock_flag,
  output logic            o_write_enable_latch,
  output logic            o_reset_command_enable,
  output logic            o_lockdown_commands_enable,
  output logic            o_erase_program_error_flag
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    fsr_mode_t  mode;
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic       got_byte;
    logic [7:0] data;
    logic [7:0] tx_sh;
    logic [2:0] tx_cnt;
    logic       tx_sel;
    logic       so;
    logic       so_oe;
    logic       sclk_q;
    logic       cs_n_q;
    logic       lock;
    logic       err;
    logic       write_enable_latch;
    logic       reset_command_enable;
    logic       lockdown_commands_enable;
  } fsr_state_t;

  fsr_state_t st_reg;
  fsr_state_t st_next;

  logic       s_sclk;
  logic       s_cs_n;
  logic       s_si;
  logic       s_wp_n;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_rise;
  logic       cs_fall;
  logic [7:0] byte_one;
  logic [7:0] byte_two;
  logic [7:0] live_byte;
  logic [7:0] rx_shifted;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  fsr_sync #(
    .W   (4),
    .RST (FSR_PIN_RST)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_spi_sclk, i_spi_cs_n, i_spi_si, i_wp_n}),
    .o_sync    ({s_sclk, s_cs_n, s_si, s_wp_n})
  );

  assign sclk_rise  = s_sclk & ~st_reg.sclk_q & ~s_cs_n;
  assign sclk_fall  = ~s_sclk & st_reg.sclk_q & ~s_cs_n;
  assign cs_rise    = s_cs_n & ~st_reg.cs_n_q;
  assign cs_fall    = ~s_cs_n & st_reg.cs_n_q;
  assign rx_shifted = {st_reg.rx_sh[6:0], s_si};

  // ------------------------------------------------------------------
  // live status bytes
  // ------------------------------------------------------------------
  always_comb begin
    byte_one = '0;
    byte_one[FSR_B1_LOCK] = st_reg.lock;                      // [RULE7]
    byte_one[FSR_B1_RSV]  = 1'b0;                             // [RULE8]
    byte_one[FSR_B1_ERR]  = st_reg.err;                       // [RULE9]
    byte_one[FSR_B1_WPP]  = s_wp_n;                           // [RULE12]
    byte_one[FSR_B1_SWP_H:FSR_B1_SWP_L] =
      i_software_protect_summary;                            // [RULE13]
    byte_one[FSR_B1_WEL]  = st_reg.write_enable_latch;                       // [RULE14]
    byte_one[FSR_BX_BUSY] = i_busy;                           // [RULE15]
    byte_two = '0;
    byte_two[FSR_B2_RSV_H:FSR_B2_RSV_L] = FSR_RSV2;           // [RULE8]
    byte_two[FSR_B2_RESET_COMMAND_ENABLE] = st_reg.reset_command_enable;                      // [RULE16]
    byte_two[FSR_B2_SLE]  = st_reg.lockdown_commands_enable;                       // [RULE17]
    byte_two[FSR_B2_PS]   = i_program_suspended_flag;         // [RULE18]
    byte_two[FSR_B2_ES]   = i_erase_suspended_flag;           // [RULE18]
    byte_two[FSR_BX_BUSY] = i_busy;                           // [RULE3]
    live_byte = st_reg.tx_sel ? byte_two : byte_one;
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.sclk_q = s_sclk;
    st_next.cs_n_q = s_cs_n;

    // error flag follows each finished operation; aborts never reach it
    if (i_op_done) begin
      st_next.err = i_op_fail;                      // [RULE10] [RULE11]
    end
    if (i_wel_clear) begin
      st_next.write_enable_latch = 1'b0;
    end
    if (i_lockdown_frozen) begin
      st_next.lockdown_commands_enable = 1'b0;
    end

    if (s_cs_n) begin
      st_next.so_oe = 1'b0;                                   // [RULE6]
      st_next.so    = 1'b0;
    end

    if (cs_fall) begin
      st_next.mode     = FSR_M_OPCODE;
      st_next.rx_cnt   = FSR_BIT0;
      st_next.got_byte = 1'b0;
      st_next.tx_cnt   = FSR_BIT0;
      st_next.tx_sel   = 1'b0;
    end else if (cs_rise) begin
      // write enable and status data take effect only on a whole-byte release; write disable on any release
      case (st_reg.mode)
        FSR_M_WREN: begin
          if (st_reg.rx_cnt == FSR_BIT0) begin
            st_next.write_enable_latch = 1'b1;
          end
        end
        FSR_M_WRDI: begin
          st_next.write_enable_latch = 1'b0;
        end
        FSR_M_WSR1: begin
          if (st_reg.write_enable_latch) begin
            st_next.write_enable_latch = 1'b0;                               // [RULE24]
            if (st_reg.got_byte && st_reg.rx_cnt == FSR_BIT0 &&
                !(!s_wp_n && st_reg.lock &&
                  !st_reg.data[FSR_B1_LOCK])) begin
              st_next.lock = st_reg.data[FSR_B1_LOCK];        // [RULE22]
            end
          end
        end
        FSR_M_WSR2: begin
          if (st_reg.write_enable_latch) begin
            st_next.write_enable_latch = 1'b0;
            if (st_reg.got_byte && st_reg.rx_cnt == FSR_BIT0) begin
              st_next.reset_command_enable = st_reg.data[FSR_B2_RESET_COMMAND_ENABLE];        // [RULE19]
              st_next.lockdown_commands_enable  = st_reg.data[FSR_B2_SLE] &
                             ~i_lockdown_frozen;
            end
          end
        end
        default: begin
        end
      endcase
      st_next.mode = FSR_M_SKIP;
    end else if (sclk_rise) begin
      st_next.rx_sh  = rx_shifted;
      st_next.rx_cnt = st_reg.rx_cnt + 3'h1;
      if (st_reg.rx_cnt == FSR_LAST_BIT) begin
        case (st_reg.mode)
          FSR_M_OPCODE: begin
            // read status is decoded whatever the busy state
            if (rx_shifted == FSR_OP_READ_STATUS) begin
              st_next.mode = FSR_M_READ;          // [RULE1] [RULE4]
            end else if (rx_shifted == FSR_OP_WRITE_SR1) begin
              st_next.mode = FSR_M_WSR1;                      // [RULE23]
            end else if (rx_shifted == OP_WRITE_SR2) begin
              st_next.mode = FSR_M_WSR2;
            end else if (rx_shifted == OP_WREN) begin
              st_next.mode = FSR_M_WREN;
            end else if (rx_shifted == OP_WRDI) begin
              st_next.mode = FSR_M_WRDI;
            end else begin
              st_next.mode = FSR_M_SKIP;
            end
          end
          FSR_M_WSR1, FSR_M_WSR2: begin
            // only the first data byte counts
            if (!st_reg.got_byte) begin
              st_next.data = rx_shifted;
            end
            st_next.got_byte = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end else if (sclk_fall && st_reg.mode == FSR_M_READ) begin
      st_next.so_oe  = 1'b1;
      st_next.tx_cnt = st_reg.tx_cnt + 3'h1;
      if (st_reg.tx_cnt == FSR_BIT0) begin
        // fresh status sampled at the start of every byte
        st_next.so    = live_byte[7];             // [RULE3] [RULE25]
        st_next.tx_sh = {live_byte[6:0], 1'b0};
      end else begin
        st_next.so    = st_reg.tx_sh[7];                      // [RULE25]
        st_next.tx_sh = {st_reg.tx_sh[6:0], 1'b0};
      end
      if (st_reg.tx_cnt == FSR_LAST_BIT) begin
        st_next.tx_sel = ~st_reg.tx_sel;                      // [RULE2]
      end
    end
  end

  // ------------------------------------------------------------------
  // registers; lock returns to zero by power-up reset or by a status write with write protect high
  // ------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg          <= '0;
      st_reg.mode     <= FSR_M_SKIP;
      st_reg.sclk_q   <= 1'b0;
      st_reg.cs_n_q   <= 1'b1;
      st_reg.lock     <= FSR_LOCK_RST;                        // [RULE21]
      st_reg.err      <= FSR_ERR_RST;
      st_reg.write_enable_latch      <= FSR_WEL_RST;
      st_reg.reset_command_enable     <= FSR_RESET_COMMAND_ENABLE_RST;
      st_reg.lockdown_commands_enable      <= FSR_SLE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_spi_so                   = st_reg.so;
  assign o_spi_so_oe                = st_reg.so_oe;
  assign o_protection_lock_flag     = st_reg.lock;            // [RULE20]
  assign o_write_enable_latch       = st_reg.write_enable_latch;
  assign o_reset_command_enable     = st_reg.reset_command_enable;
  assign o_lockdown_commands_enable = st_reg.lockdown_commands_enable;
  assign o_erase_program_error_flag = st_reg.err;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  logic tx_load;
  assign tx_load = sclk_fall && st_reg.mode == FSR_M_READ &&
                   st_reg.tx_cnt == FSR_BIT0;

  sequence s_wsr1_end;
    st_reg.mode == FSR_M_WSR1 && st_reg.write_enable_latch && cs_rise;
  endsequence

  property p_release_floats;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_cs_n |=> !o_spi_so_oe ##1 !o_spi_so_oe;
  endproperty
  a_release_floats: assert property (p_release_floats) // [RULE6]
    else $error("output driven after chip select release");

  property p_reserved_zero;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    tx_load |=> !st_reg.tx_sh[7] &&
      (!$past(st_reg.tx_sel) || (!o_spi_so && !st_reg.tx_sh[6]));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [RULE8]
    else $error("reserved status bit not zero");

  property p_msb_first;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    tx_load |=> o_spi_so == $past(live_byte[7]) && o_spi_so_oe;
  endproperty
  a_msb_first: assert property (p_msb_first) // [RULE25]
    else $error("status byte not sent msb first");

  property p_busy_each_byte;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    tx_load |=> st_reg.tx_sh[1] == $past(i_busy);
  endproperty
  a_busy_each_byte: assert property (p_busy_each_byte) // [RULE3]
    else $error("busy not sampled for byte");

  property p_lock_held_by_wp;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !s_wp_n && st_reg.lock |=> st_reg.lock;
  endproperty
  a_lock_held_by_wp: assert property (p_lock_held_by_wp) // [RULE22]
    else $error("lock cleared while write protect asserted");

  property p_wsr1_clears_wel;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_wsr1_end |=> !st_reg.write_enable_latch;
  endproperty
  a_wsr1_clears_wel: assert property (p_wsr1_clears_wel) // [RULE24]
    else $error("write enable kept after status write");

  property p_err_refresh;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_op_done |=> o_erase_program_error_flag == $past(i_op_fail);
  endproperty
  a_err_refresh: assert property (p_err_refresh) // [RULE10]
    else $error("error flag not refreshed");

  property p_abort_no_err;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_op_abort && !i_op_done && !st_reg.err |=> !st_reg.err;
  endproperty
  a_abort_no_err: assert property (p_abort_no_err) // [RULE11]
    else $error("abort set error flag");

  property p_read_decoded;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    sclk_rise && st_reg.mode == FSR_M_OPCODE &&
    st_reg.rx_cnt == FSR_LAST_BIT && rx_shifted == FSR_OP_READ_STATUS
    |=> st_reg.mode == FSR_M_READ;
  endproperty
  a_read_decoded: assert property (p_read_decoded) // [RULE1]
    else $error("status read opcode not decoded");

endmodule

`default_nettype wire

// ### bench/fsr_host_model.sv
// host spi controller model that drives the status register block
`timescale 1ns/100ps
`default_nettype none

module fsr_host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_si
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end
  // select the device and let the synchroniser see it
  task automatic start;
    @(negedge i_sys_clk);
    o_cs_n = 1'b0;
    repeat (3) @(negedge i_sys_clk);
  endtask
  // mode 0, msb first, 80 ns clock; so is taken at the rising edge
  task automatic xfer(input  logic [7:0] tx,
                      input  int         n,
                      output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      o_si = tx[i];
      repeat (4) @(negedge i_sys_clk);
      o_sclk = 1'b1;
      // an undriven line is taken as the opposite of its last level
      rx[i]  = i_so_oe ? i_so : ~i_so;
      repeat (4) @(negedge i_sys_clk);
      o_sclk = 1'b0;
    end
  endtask
  // release select; data line flips so a stale level is never trusted
  task automatic stop;
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    repeat (8) @(negedge i_sys_clk);
  endtask
endmodule

`default_nettype wire

// ### bench/flash_status_register_read_tb_top.sv
// self-checking bench for the flash status register block
`timescale 1ns/100ps
`default_nettype none

module flash_status_register_read_tb_top
  import fsr_pkg::*;
;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_WSR2 = 8'h31;
  logic       sys_clk, rst_n, wp_n, busy, op_done, op_fail, op_abort;
  logic       ps, es, frozen, wel_clear, sclk, cs_n, si, so, so_oe;
  logic       lock, write_enable_latch, reset_command_enable, lockdown_commands_enable, err;
  logic [1:0] software_protect_summary;
  logic [7:0] b1, b2;
  int         failures, n_checks;

  fsr_status #(
    .OP_WRITE_SR2 (OP_WSR2),
    .OP_WREN      (OP_WREN),
    .OP_WRDI      (OP_WRDI)
  ) dut (
    .i_sys_clk                  (sys_clk),
    .i_rst_n                    (rst_n),
    .i_spi_sclk                 (sclk),
    .i_spi_cs_n                 (cs_n),
    .i_spi_si                   (si),
    .i_wp_n                     (wp_n),
    .i_busy                     (busy),
    .i_op_done                  (op_done),
    .i_op_fail                  (op_fail),
    .i_op_abort                 (op_abort),
    .i_software_protect_summary (software_protect_summary),
    .i_program_suspended_flag   (ps),
    .i_erase_suspended_flag     (es),
    .i_lockdown_frozen          (frozen),
    .i_wel_clear                (wel_clear),
    .o_spi_so                   (so),
    .o_spi_so_oe                (so_oe),
    .o_protection_lock_flag     (lock),
    .o_write_enable_latch       (write_enable_latch),
    .o_reset_command_enable     (reset_command_enable),
    .o_lockdown_commands_enable (lockdown_commands_enable),
    .o_erase_program_error_flag (err)
  );
  fsr_host_model host (
    .i_sys_clk (sys_clk),
    .i_so      (so),
    .i_so_oe   (so_oe),
    .o_sclk    (sclk),
    .o_cs_n    (cs_n),
    .o_si      (si)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // status read of four bytes; the later pair is kept
  task automatic rd;
    logic [7:0] r [4];
    host.start();
    host.xfer(FSR_OP_READ_STATUS, 8, r[0]);
    for (int i = 0; i < 4; i++) begin
      host.xfer(8'h00, 8, r[i]);
    end
    chk({7'h00, so_oe}, 8'h01);
    host.stop();
    chk(r[2], r[0]);
    chk(r[3], r[1]);
    b1 = r[2];
    b2 = r[3];
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] d,
                    input bit nd);
    logic [7:0] r;
    host.start();
    host.xfer(op, 8, r);
    if (nd) begin
      host.xfer(d, 8, r);
    end
    host.stop();
  endtask
  task automatic pulse(input logic f, input logic a);
    @(negedge sys_clk);
    op_done  = ~a;
    op_abort = a;
    op_fail  = f;
    @(negedge sys_clk);
    {op_done, op_abort, op_fail} = '0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic t_reset;
    rd();
    chk(b1, 8'h1C);
    chk(b2, 8'h00);
    chk({3'h0, lock, write_enable_latch, reset_command_enable, lockdown_commands_enable, err}, 8'h00);
  endtask
  // protection summary codes 0, 1 and 3, busy and suspend flags live
  task automatic t_live;
    logic [1:0] codes [3];
    codes = '{FSR_SWP_NONE, FSR_SWP_SOME, FSR_SWP_ALL};
    for (int i = 0; i < 3; i++) begin
      @(negedge sys_clk);
      software_protect_summary  = codes[i];
      busy = ~i[0];
      ps   = i[0];
      es   = ~i[0];
      wp_n = i[1];
      rd();
      chk(b1, {3'h0, wp_n, software_protect_summary, 1'b0, busy});
      chk(b2, {5'h00, ps, es, busy});
    end
    @(negedge sys_clk);
    {busy, ps, es} = '0;
  endtask
  task automatic t_err;
    pulse(1'b1, 1'b0);
    chk({7'h00, err}, 8'h01);
    rd();
    chk(b1, 8'h3C);
    pulse(1'b0, 1'b0);
    chk({7'h00, err}, 8'h00);
    pulse(1'b1, 1'b1);
    chk({7'h00, err}, 8'h00);
  endtask
  // busy changes between the bytes of one read
  task automatic t_busy;
    logic [7:0] r [3];
    @(negedge sys_clk);
    busy = 1'b1;
    host.start();
    host.xfer(FSR_OP_READ_STATUS, 8, r[0]);
    host.xfer(8'h00, 8, r[0]);
    busy = 1'b0;
    host.xfer(8'h00, 8, r[1]);
    busy = 1'b1;
    host.xfer(8'h00, 8, r[2]);
    host.stop();
    busy = 1'b0;
    chk(r[0], 8'h1D);
    chk(r[1], 8'h00);
    chk(r[2], 8'h1D);
  endtask
  task automatic t_write;
    wr(FSR_OP_WRITE_SR1, 8'h80, 1'b1);
    chk({6'h00, lock, write_enable_latch}, 8'h00);
    wr(OP_WREN, 8'h00, 1'b0);
    rd();
    chk(b1, 8'h1E);
    wr(OP_WRDI, 8'h00, 1'b0);
    chk({7'h00, write_enable_latch}, 8'h00);
    wr(OP_WREN, 8'h00, 1'b0);
    wel_clear = 1'b1;
    @(negedge sys_clk);
    wel_clear = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({7'h00, write_enable_latch}, 8'h00);
    wr(OP_WREN, 8'h00, 1'b0);
    wr(FSR_OP_WRITE_SR1, 8'hFF, 1'b1);
    rd();
    chk(b1, 8'h9C);
    wp_n = 1'b0;
    wr(OP_WREN, 8'h00, 1'b0);
    wr(FSR_OP_WRITE_SR1, 8'h00, 1'b1);
    chk({6'h00, lock, write_enable_latch}, 8'h02);
    wp_n = 1'b1;
    wr(OP_WREN, 8'h00, 1'b0);
    wr(FSR_OP_WRITE_SR1, 8'h00, 1'b1);
    chk({6'h00, lock, write_enable_latch}, 8'h00);
    wp_n = 1'b0;
    wr(OP_WREN, 8'h00, 1'b0);
    wr(FSR_OP_WRITE_SR1, 8'h80, 1'b1);
    chk({6'h00, lock, write_enable_latch}, 8'h02);
    wr(OP_WREN, 8'h00, 1'b0);
    wr(OP_WSR2, 8'hFF, 1'b1);
    rd();
    chk(b2, 8'h18);
    frozen = 1'b1;
    wr(OP_WREN, 8'h00, 1'b0);
    wr(OP_WSR2, 8'h08, 1'b1);
    chk({6'h00, reset_command_enable, lockdown_commands_enable}, 8'h00);
  endtask
  // select dropped three bits into byte one
  task automatic t_cut;
    logic [7:0] r;
    host.start();
    host.xfer(FSR_OP_READ_STATUS, 8, r);
    host.xfer(8'h00, 3, r);
    chk({5'h00, r[7:5]}, 8'h04);
    chk({7'h00, so_oe}, 8'h01);
    host.stop();
    chk({7'h00, so_oe}, 8'h00);
  endtask
  // partial write refused, then a second power-up reset clears the lock
  task automatic t_por;
    logic [7:0] r;
    wp_n = 1'b1;
    wr(OP_WREN, 8'h00, 1'b0);
    host.start();
    host.xfer(FSR_OP_WRITE_SR1, 8, r);
    host.xfer(8'h00, 4, r);
    host.stop();
    chk({6'h00, lock, write_enable_latch}, 8'h02);
    rst_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk({4'h0, so_oe, lock, write_enable_latch, err}, 8'h00);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd();
    chk(b1, 8'h1C);
  endtask

  initial begin
    {sys_clk, rst_n, busy, op_done, op_fail, op_abort} = '0;
    {ps, es, frozen, wel_clear} = '0;
    {failures, n_checks} = '0;
    wp_n = 1'b1;
    software_protect_summary  = FSR_SWP_ALL;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_live();
    t_err();
    t_busy();
    t_write();
    t_cut();
    t_por();
    wrap_up();
  end
  initial begin
    #500us;
    failures++;
    wrap_up();
  end
endmodule

`default_nettype wire
